// [rtl/pcs_pkg.sv]
// Constants, register map and carrier types of the program counter sequencer.
// Assumes one core clock that also serves as the system clock of the core.
package pcs_pkg;

    // ==========================================================
    // Widths and timing
    localparam int PC_W = 13;
    localparam int ADDR_W = 14;
    localparam int WORD_W = 16;
    localparam int PHASES = 4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STARTUP_PERIOD_TSYS = 1024;
    localparam int STARTUP_CYC = STARTUP_PERIOD_TSYS * CLK_PERIOD_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Vectors
    localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
    localparam logic [PC_W-1:0] EXT_INT_VEC = 13'h0004;

    // ==========================================================
    // Register map: index, byte address is four times the index
    localparam logic [7:0] REG_BANK_IDX = 8'h04;
    localparam logic [7:0] REG_PCL_IDX = 8'h06;
    localparam logic [7:0] REG_STAT_IDX = 8'h08;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam int BANK_BIT = 5;
    localparam int STAT_BANK_BIT = 13;
    localparam int STAT_EXEC_BIT = 16;
    localparam int STAT_VALID_BIT = 17;
    localparam int STAT_HALT_BIT = 18;
    localparam int STAT_HOLD_BIT = 19;

    // ==========================================================
    // Carrier from the execute stage
    typedef struct packed {
        logic jump;
        logic call;
        logic ret;
        logic skip;
        logic int_ack;
        logic ext_int;
        logic halt;
        logic [PC_W-1:0] target;
        logic [PC_W-1:0] vector;
        logic [ADDR_W-1:0] stack_addr;
    } pcs_ctl_t;

endpackage : pcs_pkg

// [rtl/pcs_phase_gen.sv]
// Four-phase generator splitting the system clock into instruction phases.
// Assumes a synchronous active-high reset on core_clk.
module pcs_phase_gen #(
    parameter int PHASES = pcs_pkg::PHASES
) (
    input wire logic core_clk,
    input wire logic reset,
    output logic [PHASES-1:0] phase,
    output logic last
);

    // ==========================================================
    // Elaboration check
    generate
        if (PHASES < 2) begin : g_bad_phases
            $error("pcs_phase_gen needs at least two phases");
        end
    endgenerate

    // ==========================================================
    // One-hot rotation, one phase per clock
    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase <= PHASES'(1);
        end else begin
            phase <= {phase[PHASES-2:0], phase[PHASES-1]}; // RL1
        end
    end

    assign last = phase[PHASES-1];

endmodule : pcs_phase_gen

// [rtl/pcs_sequencer.sv]
// Program counter, fetch/execute pipeline and register port of the core.
// Assumes a synchronous program ROM that answers within three clocks,
// an execute stage on core_clk driving ctl, and an Avalon-MM master.
//
// Local design decision: the Avalon-MM interface to the registers.

// How it works
// RL1: Four phases make one instruction cycle
// RL2: Fetch next word while current word executes
// RL3: Counter change costs one dummy cycle
// RL4: Thirteen-bit counter addresses 8192 words
// RL5: Counter increments after every fetch
// RL6: Jumps, writes, calls, interrupts, returns load
// RL7: Taken skip discards prefetched word
// RL8: Counter low byte readable, writable register
// RL9: Low byte write jumps within page
// RL10: Hold execution 1024 clocks after start
// RL11: Reset starts at address zero
// RL12: External interrupt vectors to 004H bank zero
// RL13: Jump takes bank bit from selector
// RL14: Return restores full fourteen-bit address
module pcs_sequencer #(
    parameter int STARTUP_CYC = pcs_pkg::STARTUP_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire pcs_pkg::pcs_ctl_t ctl,
    input wire logic wake_pin,
    output logic [pcs_pkg::ADDR_W-1:0] rom_addr,
    input wire logic [pcs_pkg::WORD_W-1:0] rom_data,
    output logic [pcs_pkg::WORD_W-1:0] exec_word,
    output logic exec_en,
    output logic [pcs_pkg::PHASES-1:0] phase,
    output logic halted
);

    localparam int HW = $clog2(STARTUP_CYC + 1);

    // ==========================================================
    // Elaboration check
    generate
        if (STARTUP_CYC < 1 || STARTUP_CYC > 65535) begin : g_bad_startup
            $error("STARTUP_CYC out of range");
        end
    endgenerate

    // ==========================================================
    // State
    logic last;
    logic [pcs_pkg::PC_W-1:0] pc_r;
    logic bank_r;
    logic [7:0] bank_sel_r;
    logic [pcs_pkg::WORD_W-1:0] exec_word_r;
    logic valid_r;
    logic exec_en_r;
    logic halted_r;
    logic [HW-1:0] hold_cnt_r;
    logic wake_s1_r;
    logic wake_s2_r;
    logic pcl_pend_r;
    logic [7:0] pcl_data_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic run;
    logic adv;
    logic go_int;
    logic go_ret;
    logic go_jmp;
    logic go_pcl;
    logic go_skip;
    logic go_halt;
    logic flush;
    logic accept;
    logic wr_pcl;

    // ==========================================================
    // Phase generator
    pcs_phase_gen #(
        .PHASES(pcs_pkg::PHASES)
    ) u_phase (
        .core_clk(core_clk),
        .reset(reset),
        .phase(phase),
        .last(last)
    );

    // ==========================================================
    // Decode helper
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {idx[5:0], 2'b00});
    endfunction : reg_hit

    // ==========================================================
    // Pipeline advance and transfer decode
    assign run = !halted_r && (hold_cnt_r == '0); // RL10
    assign adv = last && run && (exec_en_r || !valid_r); // RL1 RL2
    assign go_int = adv && ctl.int_ack; // RL6
    assign go_ret = adv && exec_en_r && ctl.ret && !go_int; // RL6
    assign go_jmp = adv && exec_en_r && (ctl.jump || ctl.call) && !go_int && !ctl.ret; // RL6
    assign go_pcl = adv && pcl_pend_r && !go_int && !go_ret && !go_jmp; // RL9
    assign go_skip = adv && exec_en_r && ctl.skip && !go_int && !go_ret && !go_jmp
        && !go_pcl; // RL7
    assign flush = go_int || go_ret || go_jmp || go_pcl || go_skip; // RL3
    assign go_halt = adv && exec_en_r && ctl.halt && !flush;

    // ==========================================================
    // Program counter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_r <= pcs_pkg::RESET_VEC; // RL11
        end else if (go_int) begin
            pc_r <= ctl.ext_int ? pcs_pkg::EXT_INT_VEC : ctl.vector; // RL12
        end else if (go_ret) begin
            pc_r <= ctl.stack_addr[pcs_pkg::PC_W-1:0]; // RL14
        end else if (go_jmp) begin
            pc_r <= ctl.target; // RL13
        end else if (go_pcl) begin
            pc_r <= {pc_r[pcs_pkg::PC_W-1:8], pcl_data_r}; // RL9
        end else if (adv) begin
            pc_r <= pcs_pkg::PC_W'(pc_r + 1'b1); // RL4 RL5
        end
    end

    // ==========================================================
    // Bank bit of the fetch address
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bank_r <= 1'b0;
        end else if (go_int) begin
            bank_r <= 1'b0; // RL12
        end else if (go_ret) begin
            bank_r <= ctl.stack_addr[pcs_pkg::ADDR_W-1]; // RL14
        end else if (go_jmp) begin
            bank_r <= bank_sel_r[pcs_pkg::BANK_BIT]; // RL13
        end
    end

    assign rom_addr = {bank_r, pc_r};

    // ==========================================================
    // Execute slot
    always_ff @(posedge core_clk) begin
        if (reset) begin
            exec_word_r <= '0;
            valid_r <= 1'b0;
            exec_en_r <= 1'b0;
        end else if (adv) begin
            exec_word_r <= rom_data; // RL2
            valid_r <= !flush; // RL3 RL7
            exec_en_r <= !flush && !go_halt;
        end else if (last) begin
            exec_en_r <= run && valid_r;
        end
    end

    assign exec_word = exec_word_r;
    assign exec_en = exec_en_r;

    // ==========================================================
    // Halt, wake and start-up hold
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_pin;
            wake_s2_r <= wake_s1_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            halted_r <= 1'b0;
        end else if (go_halt) begin
            halted_r <= 1'b1;
        end else if (halted_r && wake_s2_r) begin
            halted_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hold_cnt_r <= HW'(STARTUP_CYC); // RL10
        end else if (halted_r && wake_s2_r) begin
            hold_cnt_r <= HW'(STARTUP_CYC); // RL10
        end else if (hold_cnt_r != '0) begin
            hold_cnt_r <= HW'(hold_cnt_r - 1'b1);
        end
    end

    assign halted = halted_r;

    // ==========================================================
    // Avalon-MM slave
    assign accept = (avs_read || avs_write) && wait_r;
    assign wr_pcl = avs_write && !wait_r && avs_byteenable[0]
        && reg_hit(avs_address, pcs_pkg::REG_PCL_IDX);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !accept;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (accept && avs_read) begin
            if (reg_hit(avs_address, pcs_pkg::REG_PCL_IDX)) begin
                rdata_r <= {24'h000000, pc_r[7:0]}; // RL8
            end else if (reg_hit(avs_address, pcs_pkg::REG_BANK_IDX)) begin
                rdata_r <= {24'h000000, bank_sel_r};
            end else if (reg_hit(avs_address, pcs_pkg::REG_STAT_IDX)) begin
                rdata_r <= '0;
                rdata_r[pcs_pkg::PC_W-1:0] <= pc_r;
                rdata_r[pcs_pkg::STAT_BANK_BIT] <= bank_r;
                rdata_r[pcs_pkg::STAT_EXEC_BIT] <= exec_en_r;
                rdata_r[pcs_pkg::STAT_VALID_BIT] <= valid_r;
                rdata_r[pcs_pkg::STAT_HALT_BIT] <= halted_r;
                rdata_r[pcs_pkg::STAT_HOLD_BIT] <= (hold_cnt_r != '0);
            end else begin
                rdata_r <= '0;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            bank_sel_r <= pcs_pkg::BANK_RST;
        end else if (avs_write && !wait_r && avs_byteenable[0]
                && reg_hit(avs_address, pcs_pkg::REG_BANK_IDX)) begin
            bank_sel_r <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pcl_pend_r <= 1'b0;
            pcl_data_r <= '0;
        end else if (wr_pcl) begin
            pcl_pend_r <= 1'b1; // RL8
            pcl_data_r <= avs_writedata[7:0];
        end else if (go_pcl) begin
            pcl_pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    logic [15:0] stall_cnt_r;

    always_ff @(posedge core_clk) begin
        if (reset || run) begin
            stall_cnt_r <= '0;
        end else if (stall_cnt_r != 16'hFFFF) begin
            stall_cnt_r <= 16'(stall_cnt_r + 1'b1);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_phase_rotation: assert property ( // RL1
        phase == 4'h1 |=> phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8 ##1 phase == 4'h1)
        else $error("phase sequence broken");
    a_pipe_fetch: assert property ( // RL2
        adv && !flush |=> exec_word == $past(rom_data) && valid_r)
        else $error("fetched word not moved to execute slot");
    a_dummy_after: assert property ( // RL3
        adv && flush |=> !exec_en [*4])
        else $error("no dummy cycle after transfer");
    a_pc_increment: assert property ( // RL5
        adv && !go_int && !go_ret && !go_jmp && !go_pcl |=> pc_r == $past(pc_r) + 13'h0001)
        else $error("counter did not increment");
    a_skip_discard: assert property ( // RL7
        go_skip |=> !valid_r && pc_r == $past(pc_r) + 13'h0001)
        else $error("taken skip kept prefetched word");
    a_pcl_short: assert property ( // RL9
        go_pcl |=> pc_r[12:8] == $past(pc_r[12:8]) && pc_r[7:0] == $past(pcl_data_r))
        else $error("low byte write changed page");
    a_hold_length: assert property ( // RL10
        $rose(run) |-> stall_cnt_r >= 16'(STARTUP_CYC))
        else $error("start-up hold too short");
    a_reset_vector: assert property ( // RL11
        $fell(reset) |-> rom_addr == 14'h0000 && !exec_en [*4])
        else $error("reset vector wrong");
    a_ext_vector: assert property ( // RL12
        go_int && ctl.ext_int |=> rom_addr == 14'h0004)
        else $error("external interrupt vector wrong");
    a_jump_bank: assert property ( // RL13
        go_jmp |=> rom_addr == {$past(bank_sel_r[5]), $past(ctl.target)})
        else $error("jump address wrong");
    a_return_full: assert property ( // RL14
        go_ret |=> rom_addr == $past(ctl.stack_addr))
        else $error("return address wrong");
    a_fetch_last_phase: assert property ( // RL1
        adv |-> last)
        else $error("fetch outside last phase");
    a_hold_blocks: assert property ( // RL10
        hold_cnt_r != '0 |-> !adv)
        else $error("pipeline advanced during hold");
    a_halt_no_exec: assert property ( // RL10
        halted_r |-> !exec_en_r)
        else $error("execution while halted");
    a_int_bank_zero: assert property ( // RL12
        go_int |=> rom_addr[13] == 1'b0)
        else $error("interrupt left bank one");
    a_jump_target: assert property ( // RL6
        go_jmp |=> pc_r == $past(ctl.target))
        else $error("jump target not loaded");
    a_skip_dummy: assert property ( // RL3
        go_skip |=> !exec_en)
        else $error("skip executed prefetched word");
    a_pcl_pending: assert property ( // RL8
        wr_pcl |=> pcl_pend_r && pcl_data_r == $past(avs_writedata[7:0]))
        else $error("low byte write lost");
    a_pcl_readback: assert property ( // RL8
        accept && avs_read && reg_hit(avs_address, pcs_pkg::REG_PCL_IDX)
        |=> avs_readdata[7:0] == $past(pc_r[7:0]))
        else $error("low byte read wrong");
    a_bus_one_wait: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");

    c_jump: cover property (go_jmp ##8 exec_en);
    c_skip: cover property (go_skip);
    c_pcl_jump: cover property (wr_pcl ##[1:8] go_pcl);
    c_wake: cover property (halted_r ##1 !halted_r);

endmodule : pcs_sequencer

// [dv/pcs_rom_model.sv]
// Program ROM model: one word per address, settles one or three clocks
// after the address moves. Assumes rom_addr holds for a whole cycle.
module pcs_rom_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic [13:0] rom_addr,
    output logic [15:0] rom_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] prev_r = 14'h0;
    logic [1:0] age_r = 2'h0;
    logic [15:0] junk_r = 16'h1234;
    // ==========================================================
    // Settling
    always_ff @(posedge core_clk) begin
        prev_r <= rom_addr;
        age_r <= (rom_addr != prev_r) ? 2'h1 : ((age_r == 2'h3) ? age_r : age_r + 2'h1);
        junk_r <= ~junk_r ^ 16'h3C5A;
    end
    // Unsettled word shows a pattern that changes every clock
    assign rom_data = (rom_addr == prev_r && age_r >= (slow ? 2'h3 : 2'h1)) ?
        ({rom_addr, 2'h1} ^ 16'hA5C3) : junk_r;
endmodule : pcs_rom_model

// [dv/program_counter_sequencer_bench.sv]
// Self-checking bench for the program counter sequencer.
// Assumes pcs_pkg, pcs_sequencer and pcs_rom_model are compiled first.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module program_counter_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 16;
    // ==========================================================
    // Signals
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    pcs_pkg::pcs_ctl_t ctl = '0;
    logic wake_pin = 1'b0;
    logic slow = 1'b0;
    logic [13:0] rom_addr;
    logic [15:0] rom_data;
    logic [15:0] exec_word;
    logic exec_en;
    logic [3:0] phase;
    logic halted;
    int errors = 0;
    int n_tests = 0;
    logic [31:0] rnd = 32'h7680;
    logic [31:0] q;
    logic [13:0] e_addr;
    logic [15:0] e_word;
    logic e_en;
    logic bank_q = 1'b0;
    logic pcl_pend = 1'b0;
    logic [7:0] pcl_q;
    always #25 core_clk = ~core_clk;
    pcs_sequencer #(.STARTUP_CYC(HOLD)) dut (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctl(ctl),
        .wake_pin(wake_pin), .rom_addr(rom_addr), .rom_data(rom_data),
        .exec_word(exec_word), .exec_en(exec_en), .phase(phase), .halted(halted));
    pcs_rom_model rom (.core_clk(core_clk), .slow(slow), .rom_addr(rom_addr),
        .rom_data(rom_data));
    // ==========================================================
    // Helpers
    function automatic logic [15:0] word_of(input logic [13:0] a);
        return {a, 2'h1} ^ 16'hA5C3;
    endfunction : word_of
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic conclude;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int i;
        @(posedge core_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin errors++; conclude(); end
    endtask : bus
    // Model one instruction cycle end, then compare
    task automatic end_cycle(input pcs_pkg::pcs_ctl_t c);
        int i;
        logic ld;
        for (i = 0; i < 8; i++) begin
            @(negedge core_clk);
            if (phase === 4'b1000) break;
        end
        if (i == 8) begin errors++; conclude(); end
        @(posedge core_clk);
        ctl <= '0;
        e_word = word_of(e_addr);
        ld = 1'b1;
        if (e_en && c.int_ack) e_addr = {1'b0, c.ext_int ? 13'h0004 : c.vector};
        else if (e_en && c.ret) e_addr = c.stack_addr;
        else if (e_en && (c.jump || c.call)) e_addr = {bank_q, c.target};
        else if (pcl_pend) begin
            e_addr = {e_addr[13:8], pcl_q};
            pcl_pend = 1'b0;
        end else begin
            ld = e_en && c.skip;
            e_addr = {e_addr[13], e_addr[12:0] + 13'h1};
        end
        e_en = !ld;
        @(negedge core_clk);
        `CHK("phase", 4'b0001, phase)
        `CHK("rom_addr", e_addr, rom_addr)
        `CHK("exec_en", e_en, exec_en)
        if (e_en) `CHK("exec_word", e_word, exec_word)
    endtask : end_cycle
    task automatic tick(input pcs_pkg::pcs_ctl_t c);
        @(posedge core_clk);
        ctl <= c;
        slow <= rnd[31];
        end_cycle(c);
    endtask : tick
    // ==========================================================
    // Main sequence
    initial begin
        pcs_pkg::pcs_ctl_t c;
        int i;
        int b;
        int n;
        logic [13:0] a;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        `CHK("rst rom_addr", 14'h0, rom_addr)
        `CHK("rst phase", 4'b0001, phase)
        `CHK("rst exec_en", 1'b0, exec_en)
        `CHK("rst wait", 1'b1, avs_waitrequest)
        for (n = 0; n < 200 && exec_en !== 1'b1; n++) @(negedge core_clk);
        `CHK("start hold", 1'b1, n >= HOLD && n < 200)
        `CHK("word 0", word_of(14'h0), exec_word)
        `CHK("addr 1", 14'h1, rom_addr)
        e_addr = 14'h1;
        e_en = 1'b1;
        for (b = 0; b < 2; b++) begin
            bus(1'b1, 8'h10, b ? 32'h20 : 32'h0, 4'hF);
            bank_q = b[0];
            end_cycle('0);
            bus(1'b0, 8'h10, 32'h0, 4'hF);
            `CHK("bank", b ? 32'h20 : 32'h0, q)
            end_cycle('0);
            for (i = 0; i < 25; i++) begin
                rnd = lfsr(rnd);
                c = '0;
                c.target = rnd[20:8];
                c.vector = rnd[20:8];
                c.stack_addr = rnd[29:16];
                if (e_en) case (rnd[2:0])
                    3'h1: c.jump = 1'b1;
                    3'h2: c.call = 1'b1;
                    3'h3: c.ret = 1'b1;
                    3'h4: c.skip = 1'b1;
                    3'h5: begin c.int_ack = 1'b1; c.ext_int = 1'b1; end
                    3'h6: c.int_ack = 1'b1;
                    default: c.halt = 1'b0;
                endcase
                tick(c);
            end
            bus(1'b0, 8'h18, 32'h0, 4'hF);
            `CHK("pcl read", {24'h0, e_addr[7:0]}, q)
            end_cycle('0);
            rnd = lfsr(rnd);
            bus(1'b1, 8'h18, rnd, 4'hF);
            pcl_q = rnd[7:0];
            pcl_pend = 1'b1;
            end_cycle('0);
            bus(1'b1, 8'h18, ~rnd, 4'h0);
            end_cycle('0);
            bus(1'b0, 8'h3C, 32'h0, 4'hF);
            `CHK("unmapped", 32'h0, q)
            end_cycle('0);
        end
        c = '0;
        c.halt = 1'b1;
        a = e_addr;
        @(posedge core_clk);
        ctl <= c;
        repeat (8) @(posedge core_clk);
        ctl <= '0;
        @(negedge core_clk);
        `CHK("halted", 1'b1, halted)
        `CHK("halt en", 1'b0, exec_en)
        @(posedge core_clk);
        wake_pin <= 1'b1;
        for (n = 0; n < 200 && exec_en !== 1'b1; n++) @(negedge core_clk);
        `CHK("wake hold", 1'b1, n >= HOLD && n < 200)
        `CHK("wake word", word_of(a), exec_word)
        `CHK("wake halted", 1'b0, halted)
        e_addr = {a[13], a[12:0] + 13'h1};
        e_en = 1'b1;
        `CHK("wake addr", e_addr, rom_addr)
        @(posedge core_clk);
        wake_pin <= 1'b0;
        repeat (4) tick('0);
        conclude();
    end
endmodule : program_counter_sequencer_bench
